// ---- core/weld_pkg.sv ----
// Purpose: shared constants and types of the weld valve sequencer
// Assumes: 20 MHz system clock, switch inputs high while closed
// Notes:   register map is word aligned on an AHB-Lite slave
package weld_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned DEBOUNCE_MS  = 5;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;

  // process output codes
  localparam logic [7:0] PO_AIR_OIL   = 8'h07;
  localparam logic [7:0] PO_PART_HOLD = 8'h1A;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SQZ_DLY = 8'h04;
  localparam logic [7:0] OFF_BLK_DLY = 8'h08;
  localparam logic [7:0] OFF_OFF     = 8'h0C;
  localparam logic [7:0] OFF_SQZ     = 8'h10;
  localparam logic [7:0] OFF_WELD    = 8'h14;
  localparam logic [7:0] OFF_HOLD    = 8'h18;
  localparam logic [7:0] OFF_SCHED   = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // control register fields
  localparam int unsigned CTRL_W   = 10;
  localparam int unsigned CTRL_EXT = 8;
  localparam int unsigned CTRL_REP = 9;

  localparam logic [5:0] SCHED_10 = 6'h0A;
  localparam logic [5:0] SCHED_20 = 6'h14;
  localparam logic [5:0] SCHED_30 = 6'h1E;

  // switch input indices
  localparam int unsigned NSW       = 7;
  localparam int unsigned IN_MAIN   = 0;
  localparam int unsigned IN_SECOND = 1;
  localparam int unsigned IN_THIRD  = 2;
  localparam int unsigned IN_TOGGLE = 3;
  localparam int unsigned IN_ESTOP  = 4;
  localparam int unsigned IN_BUTTON = 5;
  localparam int unsigned IN_KEY    = 6;

  // lamp divider: blink near 5 Hz, dim toggles fast
  localparam int unsigned DIV_W     = 22;
  localparam int unsigned BLINK_BIT = 21;
  localparam int unsigned DIM_BIT   = 8;

  typedef enum logic [8:0] {
    PH_IDLE     = 9'h001,
    PH_SQZ_DLY  = 9'h002,
    PH_SQUEEZE  = 9'h004,
    PH_WELD     = 9'h008,
    PH_HOLD     = 9'h010,
    PH_BLK_DLY  = 9'h020,
    PH_OFF      = 9'h040,
    PH_ADV_STOP = 9'h080,
    PH_HELD     = 9'h100
  } phase_t;
endpackage

// ---- core/switch_filter.sv ----
// Purpose: two-stage synchroniser and debounce for a group of switches
// Assumes: raw inputs are asynchronous to clk_sys
// Notes:   a bit changes only after STABLE equal samples
`timescale 1ns/1ps
module switch_filter #(
  parameter int unsigned W      = 7,
  parameter int unsigned CW     = 17,
  parameter int unsigned STABLE = 100000
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);
  localparam logic [CW-1:0] LIM = CW'(STABLE - 1);

  typedef struct packed {
    logic [W-1:0]         s1;
    logic [W-1:0]         s2;
    logic [W-1:0]         out;
    logic [W-1:0][CW-1:0] cnt;
  } filt_t;

  filt_t st;
  filt_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.out[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] >= LIM) begin
        next_st.out[i] = st.s2[i];
        next_st.cnt[i] = '0;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean = st.out;
endmodule

// ---- core/weld_valve_sequencer.sv ----
// Purpose: valve sequencing, schedule select and part hold of a weld
//          sequence controller, with an AHB-Lite register slave
// Assumes: switch inputs high while closed; current error pulses come
//          from measurement logic on clk_sys
// Notes:   all times count mains cycles from the zero-cross input
`timescale 1ns/1ps
module weld_valve_sequencer
  import weld_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = weld_pkg::DEBOUNCE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        main_initiation_input,
  input  wire logic        second_initiation_input,
  input  wire logic        third_initiation_input,
  input  wire logic        retract_toggle_input,
  input  wire logic        estop_input,
  input  wire logic        panel_button_input,
  input  wire logic        lockout_key_input,
  input  wire logic        mains_zero_cross,
  input  wire logic        cur_high_err,
  input  wire logic        cur_low_err,
  output logic             valve1,
  output logic             valve2,
  output logic             valve3,
  output logic             weld_fire,
  output logic             led_valve3,
  output logic             led_squeeze,
  output logic             led_off,
  output logic      [5:0]  active_sched,
  output logic             por_request
);
  import weld_pkg::*;

  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYCLES + 1);

  typedef struct packed {
    logic              pend;
    logic              wr;
    logic              hit;
    logic [7:0]        addr;
    logic [31:0]       rdata;
    logic              rdy;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        sqz_dly;
    logic [7:0]        blk_dly;
    logic [7:0]        off_t;
    logic [7:0]        sqz;
    logic [7:0]        weld;
    logic [7:0]        hold;
    logic [5:0]        sched;
    logic              mz1;
    logic              mz2;
    logic              mz3;
    logic [NSW-1:0]    prev;
    logic [DIV_W-1:0]  div;
    phase_t            phase;
    logic [7:0]        tmr;
    logic              blk;
    logic              err;
    logic              adv;
    logic [5:0]        cur_sched;
    logic              v1;
    logic              v2;
    logic              v3;
    logic              fire;
    logic              lv3;
    logic              lsq;
    logic              loff;
    logic              por;
  } seq_t;

  seq_t st;
  seq_t next_st;

  logic [NSW-1:0] clean;
  logic [NSW-1:0] rise;
  logic           air_oil;
  logic           part_hold;
  logic           estop;
  logic           held;
  logic           done;
  logic           do_start;
  logic [5:0]     start_sched;
  logic [5:0]     ext_sched;
  logic [31:0]    rd;
  logic           nao;
  logic           nph;
  logic           in_seq;

  switch_filter #(
    .W      (NSW),
    .CW     (DB_W),
    .STABLE (DEBOUNCE_CYCLES)
  ) u_filter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .raw     ({lockout_key_input, panel_button_input, estop_input,
               retract_toggle_input, third_initiation_input,
               second_initiation_input, main_initiation_input}),
    .clean   (clean)
  );

  assign rise      = clean & ~st.prev;
  assign air_oil   = st.ctrl[7:0] == PO_AIR_OIL;
  assign part_hold = st.ctrl[7:0] == PO_PART_HOLD;
  assign estop     = clean[IN_ESTOP];
  assign held      = clean[IN_MAIN];
  assign done      = st.tmr == 8'h00;

  always_comb begin
    // second and third initiation pins double as select bits
    case ({clean[IN_THIRD], clean[IN_SECOND]})
      2'b01:   ext_sched = SCHED_10;
      2'b10:   ext_sched = SCHED_20;
      2'b11:   ext_sched = SCHED_30;
      default: ext_sched = 6'h00;
    endcase
  end

  always_comb begin
    case (st.addr)
      OFF_CTRL:    rd = {22'h0, st.ctrl};
      OFF_SQZ_DLY: rd = {24'h0, st.sqz_dly};
      OFF_BLK_DLY: rd = air_oil ? {24'h0, st.blk_dly} : 32'h0;
      OFF_OFF:     rd = {24'h0, st.off_t};
      OFF_SQZ:     rd = {24'h0, st.sqz};
      OFF_WELD:    rd = {24'h0, st.weld};
      OFF_HOLD:    rd = {24'h0, st.hold};
      OFF_SCHED:   rd = {26'h0, st.sched};
      OFF_STATUS:  rd = {12'h0, st.cur_sched, st.phase, st.err,
                         st.blk, st.v3, st.v2, st.v1};
      default:     rd = 32'h0;
    endcase
    if (!st.hit) begin
      rd = 32'h0;
    end
  end

  always_comb begin
    next_st      = st;
    do_start     = 1'b0;
    start_sched  = st.sched;
    nao          = 1'b0;
    nph          = 1'b0;
    in_seq       = 1'b0;
    next_st.mz1  = mains_zero_cross;
    next_st.mz2  = st.mz1;
    next_st.mz3  = st.mz2;
    next_st.prev = clean;
    next_st.div  = st.div + 1'b1;
    next_st.por  = 1'b0;

    // bus: one wait state so read data leaves a flip-flop
    if (st.pend) begin
      next_st.pend = 1'b0;
      next_st.rdy  = 1'b1;
      if (!st.wr) begin
        next_st.rdata = rd;
      end else if (st.hit && !st.blk) begin
        case (st.addr)
          OFF_CTRL:    next_st.ctrl    = hwdata[CTRL_W-1:0];
          OFF_SQZ_DLY: next_st.sqz_dly = hwdata[7:0];
          OFF_BLK_DLY: begin
            if (air_oil) begin
              next_st.blk_dly = hwdata[7:0];
            end
          end
          OFF_OFF:     next_st.off_t   = hwdata[7:0];
          OFF_SQZ:     next_st.sqz     = hwdata[7:0];
          OFF_WELD:    next_st.weld    = hwdata[7:0];
          OFF_HOLD:    next_st.hold    = hwdata[7:0];
          OFF_SCHED:   next_st.sched   = hwdata[5:0];
          default:     next_st.ctrl    = st.ctrl;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      next_st.pend = 1'b1;
      next_st.wr   = hwrite;
      next_st.addr = haddr[7:0];
      next_st.hit  = haddr[31:8] == 24'h0;
      next_st.rdy  = 1'b0;
    end

    // phase timer advances only on mains cycles
    if (!done && st.mz2 && !st.mz3) begin
      next_st.tmr = st.tmr - 1'b1;
    end

    case (st.phase)
      PH_IDLE: begin
        if (!st.err && st.ctrl[CTRL_EXT]) begin
          do_start    = rise[IN_MAIN];
          start_sched = ext_sched;
        end else if (!st.err) begin
          do_start = |rise[IN_THIRD:IN_MAIN];
          if (rise[IN_MAIN]) begin
            start_sched = st.sched;
          end else if (rise[IN_SECOND]) begin
            start_sched = SCHED_10;
          end else begin
            start_sched = SCHED_20;
          end
        end
        if (!do_start && !st.err && air_oil && rise[IN_TOGGLE]) begin
          if (st.blk) begin
            next_st.blk = 1'b0;
          end else begin
            next_st.phase = PH_SQZ_DLY;
            next_st.tmr   = st.sqz_dly;
            next_st.adv   = 1'b1;
          end
        end
      end
      PH_SQZ_DLY: begin
        if (done && st.adv) begin
          next_st.phase = PH_ADV_STOP;
          next_st.tmr   = st.off_t;
        end else if (done) begin
          next_st.phase = PH_SQUEEZE;
          next_st.tmr   = st.sqz;
        end
      end
      PH_SQUEEZE: begin
        if (done) begin
          next_st.phase = PH_WELD;
          next_st.tmr   = st.weld;
        end
      end
      PH_WELD: begin
        if (done) begin
          next_st.phase = PH_HOLD;
          next_st.tmr   = st.hold;
        end
      end
      PH_HOLD: begin
        if (done && part_hold && st.err) begin
          next_st.phase = PH_HELD;
        end else if (done && air_oil) begin
          next_st.phase = PH_BLK_DLY;
          next_st.tmr   = st.blk_dly;
        end else if (done && st.ctrl[CTRL_REP] && held) begin
          next_st.phase = PH_OFF;
          next_st.tmr   = st.off_t;
        end else if (done) begin
          next_st.phase = PH_IDLE;
        end
      end
      PH_BLK_DLY: begin
        if (done) begin
          next_st.blk   = 1'b1;
          next_st.phase = PH_IDLE;
          if (st.ctrl[CTRL_REP] && held) begin
            if (st.off_t > st.blk_dly) begin
              next_st.phase = PH_OFF;
              next_st.tmr   = st.off_t - st.blk_dly;
            end else begin
              do_start    = 1'b1;
              start_sched = st.cur_sched;
            end
          end
        end
      end
      PH_OFF: begin
        if (done && st.ctrl[CTRL_REP] && held) begin
          do_start    = 1'b1;
          start_sched = st.cur_sched;
        end else if (done) begin
          next_st.phase = PH_IDLE;
        end
      end
      PH_ADV_STOP: begin
        if (done) begin
          next_st.blk   = 1'b1;
          next_st.adv   = 1'b0;
          next_st.phase = PH_IDLE;
        end
      end
      PH_HELD: next_st.phase = PH_HELD;
      default: next_st.phase = PH_IDLE;
    endcase

    if (do_start) begin
      next_st.cur_sched = start_sched;
      // a repeat straight out of the blocking delay skips the squeeze delay
      if (air_oil && !next_st.blk) begin
        next_st.phase = PH_SQZ_DLY;
        next_st.tmr   = st.sqz_dly;
      end else begin
        next_st.phase = PH_SQUEEZE;
        next_st.tmr   = st.sqz;
      end
      next_st.blk       = 1'b0;
    end

    // a new error wins over a clear in the same cycle
    next_st.err = (st.err && !(rise[IN_BUTTON] || rise[IN_KEY]))
                  || (part_hold && (cur_high_err || cur_low_err)
                      && (st.phase == PH_WELD || st.phase == PH_HOLD));
    if (st.err && !next_st.err) begin
      next_st.phase = PH_IDLE;
      next_st.blk   = 1'b0;
      next_st.adv   = 1'b0;
      next_st.tmr   = 8'h00;
      next_st.por   = 1'b1;
    end

    if (estop) begin
      next_st.phase = PH_IDLE;
      next_st.blk   = 1'b0;
      next_st.adv   = 1'b0;
      next_st.tmr   = 8'h00;
    end

    // outputs follow the next state so they leave flip-flops
    nao    = next_st.ctrl[7:0] == PO_AIR_OIL;
    nph    = next_st.ctrl[7:0] == PO_PART_HOLD;
    in_seq = next_st.phase == PH_SQUEEZE || next_st.phase == PH_WELD
             || next_st.phase == PH_HOLD;
    next_st.v1   = in_seq || next_st.phase == PH_SQZ_DLY
                   || (nph && next_st.phase == PH_HELD);
    next_st.v2   = in_seq && !(nao && next_st.phase == PH_SQUEEZE);
    next_st.v3   = nao ? next_st.blk
                       : nph && next_st.phase == PH_HELD;
    next_st.fire = next_st.phase == PH_WELD;
    next_st.lv3  = next_st.v3 && (!nao || next_st.div[BLINK_BIT]);
    next_st.lsq  = next_st.phase == PH_SQZ_DLY ? next_st.div[DIM_BIT]
                   : next_st.phase == PH_SQUEEZE;
    next_st.loff = next_st.phase == PH_BLK_DLY ? next_st.div[DIM_BIT]
                   : next_st.phase == PH_OFF;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st       <= '0;
      st.rdy   <= 1'b1;
      st.phase <= PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata       = st.rdata;
  assign hreadyout    = st.rdy;
  assign hresp        = 1'b0;
  assign valve1       = st.v1;
  assign valve2       = st.v2;
  assign valve3       = st.v3;
  assign weld_fire    = st.fire;
  assign led_valve3   = st.lv3;
  assign led_squeeze  = st.lsq;
  assign led_off      = st.loff;
  assign active_sched = st.cur_sched;
  assign por_request  = st.por;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_lock;
    st.pend && st.wr && st.blk |=> $stable(st.ctrl) && $stable(st.sqz_dly);
  endproperty
  a_lock: assert property (p_lock)
    else $error("write taken while locked");

  property p_toggle;
    st.phase == PH_IDLE && air_oil && st.blk && rise[IN_TOGGLE] && !estop
      && !st.err && !do_start |=> !st.blk ##1 !valve3;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle left valve on");

  property p_estop;
    estop |=> !st.blk && !valve1 && !valve2 && !weld_fire
      ##1 !valve3;
  endproperty
  a_estop: assert property (p_estop)
    else $error("estop left output on");

  property p_estop_release;
    estop ##1 !estop |-> !st.blk;
  endproperty
  a_estop_release: assert property (p_estop_release)
    else $error("valve back");

  property p_rep_short;
    st.phase == PH_BLK_DLY && done && st.ctrl[CTRL_REP] && held && !estop
      && !st.err && st.off_t <= st.blk_dly |=> st.phase == PH_SQUEEZE;
  endproperty
  a_rep_short: assert property (p_rep_short)
    else $error("extra off time");

  property p_rep_long;
    st.phase == PH_BLK_DLY && done && st.ctrl[CTRL_REP] && held && !estop
      && !st.err && st.off_t > st.blk_dly
      |=> st.phase == PH_OFF && st.blk
      && st.tmr == $past(st.off_t) - $past(st.blk_dly);
  endproperty
  a_rep_long: assert property (p_rep_long)
    else $error("bad remaining off");

  property p_dim;
    st.phase == PH_SQZ_DLY |-> led_squeeze == st.div[DIM_BIT];
  endproperty
  a_dim: assert property (p_dim)
    else $error("squeeze lamp not dimmed");

  property p_blkreg;
    st.pend && !st.wr && st.addr == OFF_BLK_DLY && !air_oil
      |=> hrdata == 32'h0;
  endproperty
  a_blkreg: assert property (p_blkreg)
    else $error("blocking delay visible");

  property p_skip;
    do_start && st.blk && !estop && !st.err |=> st.phase == PH_SQUEEZE;
  endproperty
  a_skip: assert property (p_skip)
    else $error("squeeze delay not skipped");

  property p_blk_end;
    st.phase == PH_BLK_DLY && done && !estop && !st.err
      && !(st.ctrl[CTRL_REP] && held && st.off_t <= st.blk_dly) |=> st.blk;
  endproperty
  a_blk_end: assert property (p_blk_end)
    else $error("blocking valve missing");

  property p_ext;
    st.phase == PH_IDLE && st.ctrl[CTRL_EXT] && rise[IN_MAIN] && !st.err
      && !estop |=> active_sched == $past(ext_sched);
  endproperty
  a_ext: assert property (p_ext)
    else $error("wrong external schedule");

  property p_contactor;
    part_hold && valve2 |-> $past(in_seq);
  endproperty
  a_contactor: assert property (p_contactor)
    else $error("contactor late");

  property p_alarm;
    part_hold && $stable(st.ctrl) |-> valve3 == (st.phase == PH_HELD);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm mismatch");
endmodule

// ---- verif/weld_field_model.sv ----
// Purpose: mains side of the weld valve sequencer
// Assumes: one mains cycle lasts MAINS_CYC clocks
// Notes:   zero-cross pulse is one clock wide, free running like mains
`timescale 1ns/1ps
module weld_field_model #(
  parameter int MAINS_CYC = 20
) (
  input  wire logic clk_sys,
  output logic      mains_zero_cross
);
  int cnt = 0;
  always @(posedge clk_sys) begin
    cnt <= (cnt == MAINS_CYC - 1) ? 0 : cnt + 1;
    mains_zero_cross <= (cnt == 0);
  end
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench of the weld valve sequencer
// Assumes: debounce cut to 4 clocks, mains cycle of 20 clocks
// Notes:   switches are held 12 clocks, then left 10 clocks to settle
`timescale 1ns/1ps
module tb;
  import weld_pkg::*;
  logic           clk_sys = 1'b0;
  logic           reset_n = 1'b0;
  logic           hsel = 1'b0;
  logic    [31:0] haddr = '0;
  logic    [1:0]  htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic    [31:0] hwdata = '0;
  logic [NSW-1:0] sw = '0;
  logic           hi_err = 1'b0;
  logic           lo_err = 1'b0;
  wire     [31:0] hrdata;
  wire            hreadyout;
  wire            zc;
  wire            por_request;
  wire     [5:0]  active_sched;
  wire     [3:0]  outs;
  wire     [2:0]  leds;
  wire            hresp;
  logic    [31:0] rd;
  int             por_n = 0;
  int             mismatches = 0;
  int             n_compared = 0;
  int             cycles = 0;
  logic    [39:0] cfg [7] = '{{OFF_CTRL, 32'h7}, {OFF_SQZ_DLY, 32'h2},
    {OFF_BLK_DLY, 32'h3}, {OFF_OFF, 32'h2}, {OFF_SQZ, 32'h2},
    {OFF_WELD, 32'h1}, {OFF_HOLD, 32'h1}};

  weld_field_model u_field (.clk_sys(clk_sys), .mains_zero_cross(zc));
  weld_valve_sequencer #(.DEBOUNCE_CYCLES(4)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .main_initiation_input(sw[IN_MAIN]),
    .second_initiation_input(sw[IN_SECOND]),
    .third_initiation_input(sw[IN_THIRD]),
    .retract_toggle_input(sw[IN_TOGGLE]), .estop_input(sw[IN_ESTOP]),
    .panel_button_input(sw[IN_BUTTON]), .lockout_key_input(sw[IN_KEY]),
    .mains_zero_cross(zc), .cur_high_err(hi_err), .cur_low_err(lo_err),
    .valve1(outs[0]), .valve2(outs[1]), .valve3(outs[2]),
    .weld_fire(outs[3]), .led_valve3(leds[0]), .led_squeeze(leds[1]),
    .led_off(leds[2]),
    .active_sched(active_sched), .por_request(por_request));

  always #25 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // a hang is cut short here and counted as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (por_request === 1'b1)
      por_n <= por_n + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wait_out(int i, logic e);
    int n;
    n = 0;
    while (outs[i] !== e && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("valve wait", 32'(outs[i]), 32'(e));
  endtask

  task automatic press(int i);
    sw[i] <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sw[i] <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic phase(phase_t p);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk("phase", 32'(rd[13:5]), 32'(p));
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("outs", 32'(outs), 32'h0);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    ahb(1'b0, 8'hF0, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("resp", 32'(hresp), 32'h0);
    foreach (cfg[k]) ahb(1'b1, cfg[k][39:32], cfg[k][31:0]);
    ahb(1'b0, OFF_BLK_DLY, 32'h0);
    chk("blk", rd, 32'h3);
    press(IN_MAIN);
    phase(PH_SQZ_DLY);
    wait_out(2, 1'b1);
    chk("blocked", 32'(outs), 32'h4);
    ahb(1'b1, OFF_SQZ_DLY, 32'h9);
    ahb(1'b0, OFF_SQZ_DLY, 32'h0);
    chk("locked", rd, 32'h2);
    press(IN_MAIN);
    phase(PH_SQUEEZE);
    chk("sq lamp", 32'(leds[1]), 32'h1);
    wait_out(2, 1'b1);
    press(IN_TOGGLE);
    wait_out(2, 1'b0);
    press(IN_TOGGLE);
    wait_out(0, 1'b0);
    phase(PH_ADV_STOP);
    wait_out(2, 1'b1);
    press(IN_ESTOP);
    wait_out(2, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk("v3 after stop", 32'(outs[2]), 32'h0);
    press(IN_MAIN);
    wait_out(3, 1'b1);
    sw[IN_ESTOP] <= 1'b1;
    wait_out(0, 1'b0);
    chk("abort", 32'(outs), 32'h0);
    sw[IN_ESTOP] <= 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int k = 1; k <= 2; k++) begin
      press(IN_ESTOP);
      press(k);
      wait_out(2, 1'b1);
      chk("sched", 32'(active_sched), 32'(k * 10));
    end
    press(IN_ESTOP);
    ahb(1'b1, OFF_CTRL, 32'h107);
    for (int k = 0; k < 4; k++) begin
      sw[IN_SECOND] <= k[0];
      sw[IN_THIRD]  <= k[1];
      press(IN_ESTOP);
      press(IN_MAIN);
      wait_out(2, 1'b1);
      chk("ext sched", 32'(active_sched), 32'(k * 10));
    end
    sw[IN_SECOND] <= 1'b0;
    sw[IN_THIRD]  <= 1'b0;
    press(IN_ESTOP);
    ahb(1'b1, OFF_CTRL, 32'h1A);
    ahb(1'b0, OFF_BLK_DLY, 32'h0);
    chk("blk hidden", rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      press(IN_MAIN);
      wait_out(3, 1'b1);
      {lo_err, hi_err} <= (k == 1) ? 2'b10 : 2'b01;
      @(posedge clk_sys);
      {lo_err, hi_err} <= 2'b00;
      wait_out(1, 1'b0);
      phase(PH_HELD);
      chk("held", 32'(outs), 32'h5);
      chk("v3 lamp", 32'(leds[0]), 32'h1);
      press((k == 1) ? IN_KEY : IN_BUTTON);
      wait_out(0, 1'b0);
      chk("cleared", 32'(outs), 32'h0);
      chk("por", 32'(por_n), 32'(k + 1));
    end
    press(IN_MAIN);
    wait_out(1, 1'b1);
    wait_out(1, 1'b0);
    chk("head off", 32'(outs[0]), 32'h0);
    // repeat with main held: short off time, then long off time
    ahb(1'b1, OFF_CTRL, 32'h207);
    sw[IN_MAIN] <= 1'b1;
    wait_out(3, 1'b1);
    wait_out(0, 1'b0);
    wait_out(0, 1'b1);
    phase(PH_SQUEEZE);
    ahb(1'b1, OFF_OFF, 32'h5);
    wait_out(2, 1'b1);
    phase(PH_OFF);
    chk("off lamp", 32'(leds[2]), 32'h1);
    wait_out(2, 1'b0);
    phase(PH_SQUEEZE);
    sw[IN_MAIN] <= 1'b0;
    wait_out(2, 1'b1);
    give_verdict();
  end
endmodule
